// ---- mas_cfg.svh ----
// Purpose: constants of the meter aggregate and scaling block
// Assumes: 100 MHz module clock, values in milli units (multiplier -3)
// Notes: energy inputs count in units of 0.00001 kWh
`ifndef MAS_CFG_SVH
`define MAS_CFG_SVH

`define MAS_CLK_HZ 100_000_000
`define MAS_CYCLE_MS 500

// rated primary current bands, upper ends in A
`define MAS_I_BAND0_MAX 32'h0000_001E
`define MAS_I_BAND1_MAX 32'h0000_012C
`define MAS_I_BAND2_MAX 32'h0000_0BB8
// rated primary voltage bands, upper ends in V
`define MAS_V_BAND0_MAX 32'h0000_00DC
`define MAS_V_BAND1_MAX 32'h0000_0898

// quantisation steps in milli units
`define MAS_STEP_1 32'h0000_0001
`define MAS_STEP_10 32'h0000_000A
`define MAS_STEP_100 32'h0000_0064
`define MAS_STEP_1000 32'h0000_03E8
`define MAS_STEP_10000 32'h0000_2710

// full load power class limits, in W
`define MAS_FLP_LIM1 64'h0000_0000_0000_2EE0
`define MAS_FLP_LIM2 64'h0000_0000_0001_D4C0
`define MAS_FLP_LIM3 64'h0000_0000_0012_4F80
`define MAS_FLP_LIM4 64'h0000_0000_00B7_1B00
// three-phase factor sqrt(3) as 1732 / 1000
`define MAS_SQRT3_NUM 64'h0000_0000_0000_06C4
`define MAS_SQRT3_DEN 64'h0000_0000_0000_03E8

// energy wraps after nine counted digits
`define MAS_EN_WRAP 32'h3B9A_CA00

`endif

// ---- mas_extreme.sv ----
// Purpose: hold highest and lowest of selected lanes since last restart
// Assumes: take is a one-cycle pulse per measuring cycle
// Notes: a restart in the cycle of a take seeds from that take
`timescale 1ns/10ps
`default_nettype none
module mas_extreme
    import mas_pkg::*;
#(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // samples
    input wire logic [N*32-1:0] samples,
    input wire logic [N-1:0] lane_en,
    input wire logic take,
    input wire logic restart,
    // held extremes
    output logic signed [31:0] max_r,
    output logic signed [31:0] min_r
);
    logic fresh_r;
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    logic signed [31:0] s;

    always_comb begin
        hi = 32'sh8000_0000;
        lo = 32'sh7FFF_FFFF;
        s = 32'sh0000_0000;
        for (int k = 0; k < N; k++) begin
            s = $signed(samples[k*32 +: 32]);
            if (lane_en[k] && s > hi) begin
                hi = s;
            end
            if (lane_en[k] && s < lo) begin
                lo = s;
            end
        end
    end

    // next take after a restart starts from fresh samples
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fresh_r <= 1'b1;
        end else if (take) begin
            fresh_r <= 1'b0;
        end else if (restart) begin
            fresh_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            max_r <= 32'sh0000_0000;
            min_r <= 32'sh0000_0000;
        end else if (take) begin
            if (fresh_r || restart || hi > max_r) begin
                max_r <= hi;
            end
            if (fresh_r || restart || lo < min_r) begin
                min_r <= lo;
            end
        end
    end
endmodule
`default_nettype wire

// ---- mas_host_model.sv ----
// Purpose: host side that reads the measurement memory once per update
// Assumes: meas_update marks the cycle in which fresh values stand
// Notes: upd_cnt lets the bench wait on whole measuring cycles
`timescale 1ns/10ps
`default_nettype none
module mas_host_model
    import mas_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // measurement memory
    input wire logic meas_update,
    input wire logic [31:0] cur_avg_out,
    // host view
    output logic [31:0] upd_cnt,
    output logic [31:0] avg_seen
);
    // read only in the cycle the pulse stands
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            upd_cnt <= 32'h0000_0000;
            avg_seen <= 32'h0000_0000;
        end else if (meas_update) begin
            upd_cnt <= upd_cnt + 32'h0000_0001;
            avg_seen <= cur_avg_out;
        end
    end
endmodule
`default_nettype wire

// ---- mas_pkg.sv ----
// Purpose: types of the meter aggregate and scaling block
// Assumes: nothing beyond the constants header
// Notes: enum codes count up from 0 in declaration order
package mas_pkg;

    typedef enum logic [1:0] {
        MAS_WS_1P2W,
        MAS_WS_1P3W,
        MAS_WS_3P3W
    } mas_wire_e;

    typedef enum logic [2:0] {
        MAS_PC_I,
        MAS_PC_II,
        MAS_PC_III,
        MAS_PC_IV,
        MAS_PC_V
    } mas_class_e;

    typedef logic signed [31:0] mas_val_t;

endpackage

// ---- mas_quant.sv ----
// Purpose: clear every digit finer than the chosen step
// Assumes: step is nonzero and positive
// Notes: signed values truncate toward zero
`timescale 1ns/10ps
`default_nettype none
module mas_quant
    import mas_pkg::*;
(
    // value in
    input wire logic signed [31:0] value,
    input wire logic [31:0] step,
    // value out
    output logic signed [31:0] quant
);
    always_comb begin
        quant = value - (value % $signed(step));
    end
endmodule
`default_nettype wire

// ---- mas_top.sv ----
// Purpose: averages, extremes and resolution scaling of meter measurements
// Assumes: samples are steady and synchronous to clock; values in milli units
// Notes: all outputs refresh together on the measuring cycle pulse
`include "mas_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mas_top
    import mas_pkg::*;
#(
    parameter int CYCLE_CLKS = (`MAS_CLK_HZ / 1000) * `MAS_CYCLE_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // configuration
    input wire logic [1:0] wire_sys,
    input wire logic [15:0] rated_volt,
    input wire logic [15:0] rated_cur,
    input wire logic extreme_clear,
    // per-phase samples, milli units
    input wire logic [31:0] cur_p1,
    input wire logic [31:0] cur_p2,
    input wire logic [31:0] cur_p3,
    input wire logic [31:0] dem_p1,
    input wire logic [31:0] dem_p2,
    input wire logic [31:0] dem_p3,
    input wire logic [31:0] volt_12,
    input wire logic [31:0] volt_23,
    input wire logic [31:0] volt_31,
    input wire logic signed [31:0] pwr,
    input wire logic signed [31:0] pwr_dem,
    input wire logic signed [31:0] pf,
    input wire logic [31:0] freq,
    // energy counts, 0.00001 kWh units
    input wire logic [31:0] en_cons,
    input wire logic [31:0] en_regen,
    input wire logic [31:0] en_react,
    input wire logic [31:0] en_per1,
    input wire logic [31:0] en_per2,
    // scaled results
    output logic meas_update,
    output logic [2:0] pwr_class,
    output logic [31:0] cur_p1_out,
    output logic [31:0] cur_p2_out,
    output logic [31:0] cur_p3_out,
    output logic [31:0] cur_avg_out,
    output logic [31:0] dem_p1_out,
    output logic [31:0] dem_p2_out,
    output logic [31:0] dem_p3_out,
    output logic [31:0] volt_12_out,
    output logic [31:0] volt_23_out,
    output logic [31:0] volt_31_out,
    output logic [31:0] volt_avg_out,
    output logic signed [31:0] pwr_out,
    output logic signed [31:0] pwr_dem_out,
    output logic signed [31:0] pf_out,
    output logic [31:0] freq_out,
    // extremes
    output logic [31:0] dem_max_out,
    output logic [31:0] dem_min_out,
    output logic [31:0] volt_max_out,
    output logic [31:0] volt_min_out,
    // scaled energies
    output logic [31:0] en_cons_out,
    output logic [31:0] en_regen_out,
    output logic [31:0] en_react_out,
    output logic [31:0] en_per1_out,
    output logic [31:0] en_per2_out
);
    localparam int NQ = 15;
    localparam int NE = 5;
    localparam int Q_C1 = 0;
    localparam int Q_C2 = 1;
    localparam int Q_C3 = 2;
    localparam int Q_CA = 3;
    localparam int Q_D1 = 4;
    localparam int Q_D2 = 5;
    localparam int Q_D3 = 6;
    localparam int Q_V12 = 7;
    localparam int Q_V23 = 8;
    localparam int Q_V31 = 9;
    localparam int Q_VA = 10;
    localparam int Q_P = 11;
    localparam int Q_PD = 12;
    localparam int Q_PF = 13;
    localparam int Q_F = 14;

    mas_wire_e ws;
    mas_class_e cls;
    logic two_wire;
    logic tick;
    logic [31:0] cyc_r;
    logic [31:0] cur_step;
    logic [31:0] volt_step;
    logic [31:0] pwr_step;
    logic [32:0] cur_sum;
    logic [32:0] volt_sum;
    logic [31:0] raw [NQ];
    logic [31:0] step [NQ];
    logic [31:0] q [NQ];
    logic [31:0] q_r [NQ];
    logic [31:0] en_raw [NE];
    logic [31:0] en_r [NE];
    logic signed [31:0] dmax;
    logic signed [31:0] dmin;
    logic signed [31:0] vmax;
    logic signed [31:0] vmin;
    logic [2:0] dem_lanes;
    logic [2:0] volt_lanes;

    function automatic logic [31:0] band_step(input logic [31:0] rated,
                                              input logic [31:0] lim0,
                                              input logic [31:0] lim1,
                                              input logic [31:0] lim2,
                                              input logic [31:0] s0);
        logic [31:0] s;
        if (rated <= lim0) begin
            s = s0;
        end else if (rated <= lim1) begin
            s = s0 * 32'h0000_000A;
        end else if (rated <= lim2) begin
            s = s0 * 32'h0000_0064;
        end else begin
            s = s0 * 32'h0000_03E8;
        end
        return s;
    endfunction

    function automatic mas_class_e class_of(input mas_wire_e w,
                                            input logic [15:0] v,
                                            input logic [15:0] i);
        logic [63:0] va;
        mas_class_e c;
        va = 64'(v) * 64'(i);
        case (w)
            MAS_WS_1P3W: va = va << 1;
            MAS_WS_3P3W: va = (va * `MAS_SQRT3_NUM) / `MAS_SQRT3_DEN;
            default: va = va;
        endcase
        if (va < `MAS_FLP_LIM1) begin
            c = MAS_PC_I;
        end else if (va < `MAS_FLP_LIM2) begin
            c = MAS_PC_II;
        end else if (va < `MAS_FLP_LIM3) begin
            c = MAS_PC_III;
        end else if (va < `MAS_FLP_LIM4) begin
            c = MAS_PC_IV;
        end else begin
            c = MAS_PC_V;
        end
        return c;
    endfunction

    function automatic logic [31:0] en_scale(input logic [31:0] e, input mas_class_e c);
        logic [31:0] d;
        case (c)
            MAS_PC_II: d = e / `MAS_STEP_10;
            MAS_PC_III: d = e / `MAS_STEP_100;
            MAS_PC_IV: d = e / `MAS_STEP_1000;
            MAS_PC_V: d = e / `MAS_STEP_10000;
            default: d = e;
        endcase
        return d % `MAS_EN_WRAP;
    endfunction

    // configuration decode
    always_comb begin
        case (wire_sys)
            2'h1: ws = MAS_WS_1P3W;
            2'h2: ws = MAS_WS_3P3W;
            default: ws = MAS_WS_1P2W;
        endcase
    end

    assign two_wire = (ws == MAS_WS_1P2W);
    assign cls = class_of(ws, rated_volt, rated_cur);
    assign cur_step = band_step({16'h0000, rated_cur}, `MAS_I_BAND0_MAX, `MAS_I_BAND1_MAX,
                                `MAS_I_BAND2_MAX, `MAS_STEP_10);
    assign volt_step = band_step({16'h0000, rated_volt}, `MAS_V_BAND0_MAX,
                                 `MAS_V_BAND1_MAX, 32'hFFFF_FFFF, `MAS_STEP_100);

    // power step 1 mW in class I, tenfold per class
    always_comb begin
        case (cls)
            MAS_PC_II: pwr_step = `MAS_STEP_10;
            MAS_PC_III: pwr_step = `MAS_STEP_100;
            MAS_PC_IV: pwr_step = `MAS_STEP_1000;
            MAS_PC_V: pwr_step = `MAS_STEP_10000;
            default: pwr_step = `MAS_STEP_1;
        endcase
    end

    // measuring cycle pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cyc_r <= 32'h0000_0000;
        end else if (cyc_r == 32'(CYCLE_CLKS - 1)) begin
            cyc_r <= 32'h0000_0000;
        end else begin
            cyc_r <= cyc_r + 32'h0000_0001;
        end
    end

    assign tick = (cyc_r == 32'(CYCLE_CLKS - 1));

    // averages
    assign cur_sum = 33'(cur_p1) + 33'(cur_p3);
    assign volt_sum = 33'(volt_12) + 33'(volt_23);

    always_comb begin
        raw[Q_C1] = cur_p1;
        raw[Q_C2] = two_wire ? 32'h0000_0000 : cur_p2;
        raw[Q_C3] = two_wire ? 32'h0000_0000 : cur_p3;
        raw[Q_CA] = two_wire ? cur_p1 : cur_sum[32:1];
        raw[Q_D1] = dem_p1;
        raw[Q_D2] = two_wire ? 32'h0000_0000 : dem_p2;
        raw[Q_D3] = two_wire ? 32'h0000_0000 : dem_p3;
        raw[Q_V12] = volt_12;
        raw[Q_V23] = two_wire ? 32'h0000_0000 : volt_23;
        raw[Q_V31] = two_wire ? 32'h0000_0000 : volt_31;
        raw[Q_VA] = two_wire ? volt_12 : volt_sum[32:1];
        raw[Q_P] = pwr;
        raw[Q_PD] = pwr_dem;
        raw[Q_PF] = pf;
        raw[Q_F] = freq;
        for (int k = Q_C1; k <= Q_D3; k++) begin
            step[k] = cur_step;
        end
        for (int k = Q_V12; k <= Q_VA; k++) begin
            step[k] = volt_step;
        end
        step[Q_P] = pwr_step;
        step[Q_PD] = pwr_step;
        step[Q_PF] = `MAS_STEP_100;
        step[Q_F] = `MAS_STEP_100;
    end

    for (genvar g = 0; g < NQ; g++) begin : g_quant
        mas_quant u_quant (
            .value(raw[g]),
            .step(step[g]),
            .quant(q[g])
        );
    end

    // lanes of the extremes by wire system
    always_comb begin
        case (ws)
            MAS_WS_1P3W: begin
                dem_lanes = 3'b101;
                volt_lanes = 3'b011;
            end
            MAS_WS_3P3W: begin
                dem_lanes = 3'b111;
                volt_lanes = 3'b111;
            end
            default: begin
                dem_lanes = 3'b001;
                volt_lanes = 3'b001;
            end
        endcase
    end

    mas_extreme #(.N(3)) u_dem_ext (
        .clock(clock),
        .arst_n(arst_n),
        .samples({q[Q_D3], q[Q_D2], q[Q_D1]}),
        .lane_en(dem_lanes),
        .take(tick),
        .restart(extreme_clear),
        .max_r(dmax),
        .min_r(dmin)
    );

    mas_extreme #(.N(3)) u_volt_ext (
        .clock(clock),
        .arst_n(arst_n),
        .samples({q[Q_V31], q[Q_V23], q[Q_V12]}),
        .lane_en(volt_lanes),
        .take(tick),
        .restart(extreme_clear),
        .max_r(vmax),
        .min_r(vmin)
    );

    // energy scaling
    assign en_raw[0] = en_cons;
    assign en_raw[1] = en_regen;
    assign en_raw[2] = en_react;
    assign en_raw[3] = en_per1;
    assign en_raw[4] = en_per2;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < NE; k++) begin
                en_r[k] <= 32'h0000_0000;
            end
        end else if (tick) begin
            for (int k = 0; k < NE; k++) begin
                en_r[k] <= en_scale(en_raw[k], cls);
            end
        end
    end

    // stored results
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < NQ; k++) begin
                q_r[k] <= 32'h0000_0000;
            end
        end else if (tick) begin
            for (int k = 0; k < NQ; k++) begin
                q_r[k] <= q[k];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meas_update <= 1'b0;
            pwr_class <= 3'h0;
        end else begin
            meas_update <= tick;
            if (tick) begin
                pwr_class <= 3'(cls);
            end
        end
    end

    assign cur_p1_out = q_r[Q_C1];
    assign cur_p2_out = q_r[Q_C2];
    assign cur_p3_out = q_r[Q_C3];
    assign cur_avg_out = q_r[Q_CA];
    assign dem_p1_out = q_r[Q_D1];
    assign dem_p2_out = q_r[Q_D2];
    assign dem_p3_out = q_r[Q_D3];
    assign volt_12_out = q_r[Q_V12];
    assign volt_23_out = q_r[Q_V23];
    assign volt_31_out = q_r[Q_V31];
    assign volt_avg_out = q_r[Q_VA];
    assign pwr_out = q_r[Q_P];
    assign pwr_dem_out = q_r[Q_PD];
    assign pf_out = q_r[Q_PF];
    assign freq_out = q_r[Q_F];
    assign dem_max_out = dmax;
    assign dem_min_out = dmin;
    assign volt_max_out = vmax;
    assign volt_min_out = vmin;
    assign en_cons_out = en_r[0];
    assign en_regen_out = en_r[1];
    assign en_react_out = en_r[2];
    assign en_per1_out = en_r[3];
    assign en_per2_out = en_r[4];
endmodule
`default_nettype wire

// ---- mas_top_assertions.sv ----
// Purpose: port-level checks of the aggregate and scaling block
// Assumes: inputs are sampled at the tick edge, results show one cycle later
// Notes: wire system 3 behaves as two-wire
`timescale 1ns/10ps
`default_nettype none
module mas_top_assertions
    import mas_pkg::*;
#(
    parameter int CYCLE_CLKS = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // configuration
    input wire logic [1:0] wire_sys,
    input wire logic extreme_clear,
    // results
    input wire logic meas_update,
    input wire logic [2:0] pwr_class,
    input wire logic [31:0] cur_p1_out,
    input wire logic [31:0] cur_p2_out,
    input wire logic [31:0] cur_avg_out,
    input wire logic [31:0] dem_p1_out,
    input wire logic [31:0] dem_p2_out,
    input wire logic [31:0] volt_12_out,
    input wire logic [31:0] volt_23_out,
    input wire logic [31:0] volt_31_out,
    input wire logic [31:0] volt_avg_out,
    input wire logic signed [31:0] pf_out,
    input wire logic [31:0] freq_out,
    input wire logic [31:0] dem_max_out,
    input wire logic [31:0] dem_min_out,
    input wire logic [31:0] volt_max_out,
    input wire logic [31:0] volt_min_out,
    input wire logic [31:0] en_cons_out
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [31:0] gap_r;
    logic fresh_r;
    // cycles since the last update pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gap_r <= 32'h0000_0000;
        end else begin
            gap_r <= meas_update ? 32'h0000_0001 : gap_r + 32'h0000_0001;
        end
    end
    // next update must show extremes seeded fresh
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fresh_r <= 1'b1;
        end else if (extreme_clear) begin
            fresh_r <= 1'b1;
        end else if (meas_update) begin
            fresh_r <= 1'b0;
        end
    end
    sequence s_tick_2w;
        meas_update && ($past(wire_sys) == 2'd0 || $past(wire_sys) == 2'd3);
    endsequence
    sequence s_fresh_2w;
        meas_update && fresh_r && ($past(wire_sys) == 2'd0 || $past(wire_sys) == 2'd3);
    endsequence
    a_update_period: assert property (
        meas_update |-> gap_r == CYCLE_CLKS) else $error("update spacing wrong");
    a_update_bound: assert property (
        gap_r <= CYCLE_CLKS) else $error("update overdue");
    a_pulse_single: assert property (
        meas_update |=> !meas_update) else $error("update pulse too long");
    a_hold_between: assert property (
        !meas_update |-> $stable(cur_avg_out) && $stable(dem_max_out) && $stable(en_cons_out))
        else $error("output changed between updates");
    a_two_wire_avg: assert property (
        s_tick_2w |-> cur_avg_out == cur_p1_out && volt_avg_out == volt_12_out)
        else $error("two-wire average wrong");
    a_two_wire_zero: assert property (
        s_tick_2w |-> cur_p2_out == '0 && dem_p2_out == '0 && volt_23_out == '0 && volt_31_out == '0)
        else $error("two-wire unused lane not zero");
    a_ext_bounds: assert property (
        meas_update |-> dem_max_out >= dem_p1_out && dem_min_out <= dem_p1_out
            && volt_max_out >= volt_12_out && volt_min_out <= volt_12_out)
        else $error("extreme outside sample");
    a_fresh_restart: assert property (
        s_fresh_2w |-> dem_max_out == dem_p1_out && dem_min_out == dem_p1_out
            && volt_max_out == volt_12_out && volt_min_out == volt_12_out)
        else $error("extremes not reseeded");
    a_quant_step: assert property (
        meas_update |-> pf_out % 100 == 0 && freq_out % 100 == 0
            && cur_p1_out % 10 == 0 && volt_12_out % 100 == 0)
        else $error("fine digits not cleared");
    a_class_energy: assert property (
        pwr_class <= 3'd4 && en_cons_out < 32'h3B9A_CA00) else $error("class or energy range");
endmodule
bind mas_top mas_top_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) mas_top_assertions_i (.*);
`default_nettype wire

// ---- tb_mas_top.sv ----
// Purpose: self-checking bench of the aggregate and scaling block
// Assumes: measuring cycle shortened to 8 clocks
// Notes: each check after t_reset waits for two host reads so the sample is fresh
`timescale 1ns/10ps
`default_nettype none
module tb_mas_top
    import mas_pkg::*;
;
    localparam int N_CLK = 8;
    logic clock = 1'b0;
    logic arst_n, extreme_clear, meas_update;
    logic [1:0] wire_sys;
    logic [2:0] pwr_class;
    logic [15:0] rated_volt, rated_cur;
    logic [31:0] cur_p1, cur_p2, cur_p3, dem_p1, dem_p2, dem_p3, volt_12, volt_23, volt_31, freq;
    logic signed [31:0] pwr, pwr_dem, pf, pwr_out, pwr_dem_out, pf_out;
    logic [31:0] en_cons, en_regen, en_react, en_per1, en_per2, upd_cnt, avg_seen;
    logic [31:0] cur_p1_out, cur_p2_out, cur_p3_out, cur_avg_out, dem_p1_out, dem_p2_out;
    logic [31:0] dem_p3_out, volt_12_out, volt_23_out, volt_31_out, volt_avg_out, freq_out;
    logic [31:0] dem_max_out, dem_min_out, volt_max_out, volt_min_out;
    logic [31:0] en_cons_out, en_regen_out, en_react_out, en_per1_out, en_per2_out;
    int num_errors = 0;
    int tests_run = 0;

    mas_top #(.CYCLE_CLKS(N_CLK)) mas_top_i (.*);
    mas_host_model mas_host_model_i (.*);

    always #5 clock = ~clock;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task wait_upd;
        logic [31:0] c0;
        int n;
        @(negedge clock);
        c0 = upd_cnt;
        n = 0;
        while (upd_cnt < c0 + 32'h0000_0002 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, upd_cnt, c0 + 32'h0000_0002);
        end
    endtask

    task drv(input logic [1:0] w, input int a, b, c, x, y, z);
        @(posedge clock);
        wire_sys <= w;
        {cur_p1, cur_p2, cur_p3} <= {32'(a), 32'(b), 32'(c)};
        {dem_p1, dem_p2, dem_p3} <= {32'(a), 32'(b), 32'(c)};
        {volt_12, volt_23, volt_31} <= {32'(x), 32'(y), 32'(z)};
    endtask

    task clr;
        @(posedge clock);
        extreme_clear <= 1'b1;
        @(posedge clock);
        extreme_clear <= 1'b0;
    endtask

    task t_reset;
        int n;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        chk(cur_avg_out, '0);
        chk(dem_max_out, '0);
        @(posedge clock);
        arst_n <= 1'b1;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (meas_update !== 1'b1 && n < 50);
        // the release edge itself does not count, so the pulse shows one negedge later
        chk(32'(n), 32'(N_CLK + 1));
        $display("t_reset done");
    endtask

    task t_avg;
        logic two;
        for (int w = 0; w < 4; w++) begin
            drv(2'(w), 12345, 7777, 23457, 101234, 103456, 99999);
            wait_upd();
            two = (w == 0 || w == 3);
            chk(cur_p1_out, 12340);
            chk(cur_avg_out, two ? 12340 : 17900);
            chk(avg_seen, two ? 12340 : 17900);
            chk(volt_avg_out, two ? 101200 : 102300);
            chk(cur_p3_out, two ? 0 : 23450);
            chk(dem_p2_out, two ? 0 : 7770);
            chk(volt_31_out, two ? 0 : 99900);
        end
        $display("t_avg done");
    endtask

    task automatic t_res;
        int rc[6] = '{30, 40, 300, 400, 3000, 4000};
        int ec[6] = '{1234560, 1234500, 1234500, 1234000, 1234000, 1230000};
        int rv[6] = '{220, 440, 2200, 3300, 110, 6600};
        int ev[6] = '{6543200, 6543000, 6543000, 6540000, 6543200, 6540000};
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            rated_cur <= 16'(rc[i]);
            rated_volt <= 16'(rv[i]);
            drv(2'd2, 1234567, 1234567, 1234567, 6543219, 6543219, 6543219);
            wait_upd();
            chk(cur_p2_out, ec[i]);
            chk(dem_p3_out, ec[i]);
            chk(volt_23_out, ev[i]);
            chk(pf_out, -12300);
            chk(freq_out, 50000);
        end
        $display("t_res done");
    endtask

    task automatic t_class;
        int cl[7][4] = '{'{0, 110, 5, 0}, '{0, 110, 300, 1}, '{0, 1100, 300, 2},
            '{0, 2200, 3000, 3}, '{0, 6600, 6000, 4}, '{1, 110, 60, 1}, '{2, 110, 60, 0}};
        int p;
        for (int i = 0; i < 7; i++) begin
            @(posedge clock);
            rated_volt <= 16'(cl[i][1]);
            rated_cur <= 16'(cl[i][2]);
            drv(2'(cl[i][0]), 1000, 1000, 1000, 200000, 200000, 200000);
            wait_upd();
            p = 10 ** cl[i][3];
            chk(pwr_class, cl[i][3]);
            chk(pwr_out, -123456 - (-123456 % p));
            chk(pwr_dem_out, 654321 - (654321 % p));
            chk(en_cons_out, 987654321 / p);
            chk(en_react_out, 987654321 / p);
            chk(en_per2_out, 987654321 / p);
            chk(en_regen_out, 987654321 / p);
            chk(en_per1_out, 987654321 / p);
        end
        $display("t_class done");
    endtask

    task automatic t_extreme;
        int ex[4][12] = '{
            '{2, 1000, 5000, 3000, 100000, 300000, 200000, 1, 5000, 1000, 300000, 100000},
            '{2, 2000, 2000, 2000, 200000, 200000, 200000, 0, 5000, 1000, 300000, 100000},
            '{1, 4000, 9000, 6000, 150000, 120000, 900000, 1, 6000, 4000, 150000, 120000},
            '{0, 7000, 100, 50, 130000, 10, 10, 1, 7000, 7000, 130000, 130000}};
        @(posedge clock);
        rated_cur <= 16'h0005;
        rated_volt <= 16'h006E;
        for (int i = 0; i < 4; i++) begin
            drv(2'(ex[i][0]), ex[i][1], ex[i][2], ex[i][3], ex[i][4], ex[i][5], ex[i][6]);
            if (ex[i][7] != 0) begin
                clr();
            end
            wait_upd();
            chk(dem_max_out, ex[i][8]);
            chk(dem_min_out, ex[i][9]);
            chk(volt_max_out, ex[i][10]);
            chk(volt_min_out, ex[i][11]);
        end
        $display("t_extreme done");
    endtask

    initial begin
        arst_n <= 1'b0;
        extreme_clear <= 1'b0;
        wire_sys <= 2'd0;
        rated_volt <= 16'h006E;
        rated_cur <= 16'h0005;
        {cur_p1, cur_p2, cur_p3, dem_p1, dem_p2, dem_p3, volt_12, volt_23, volt_31} <= '0;
        pwr <= 32'hFFFE_1DC0;
        pwr_dem <= 32'h0009_FBF1;
        pf <= 32'hFFFF_CFC7;
        freq <= 32'h0000_C381;
        {en_cons, en_regen, en_react, en_per1, en_per2} <= {5{32'h3ADE_68B1}};
        t_reset();
        t_avg();
        t_res();
        t_class();
        t_reset();
        t_extreme();
        report_and_stop();
    end

    // cuts a hang well past the expected run of about 400 clocks
    initial begin
        #200_000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
